// >>> src/cmps_pkg.sv
// constants, timing counts and types for the current-mode pwm core
// assumes a single 50 MHz clock and adc codes sampled on that clock
package cmps_pkg;
  // clock
  localparam int CLK_MHZ        = 50;
  localparam int CLK_PERIOD_NS  = 20;
  // oscillator and jitter
  localparam int OSC_FREQ_KHZ   = 100;
  localparam int OSC_PERIOD_CYC = CLK_MHZ * 1000 / OSC_FREQ_KHZ;
  localparam int JIT_DEV_KHZ    = 4;
  localparam int JIT_SPAN_CYC   = OSC_PERIOD_CYC * JIT_DEV_KHZ / OSC_FREQ_KHZ;
  localparam int JIT_PERIOD_MS  = 4;
  localparam int JIT_PERIOD_CYC = JIT_PERIOD_MS * CLK_MHZ * 1000;
  localparam int JIT_DIV_OSC    = JIT_PERIOD_CYC / (OSC_PERIOD_CYC * 4 * JIT_SPAN_CYC);
  localparam int DMAX_NUM       = 3;
  localparam int DMAX_SH        = 2;
  localparam int OSC_W          = 10;
  // minimum turn-on delay and blanking, least times rounded up
  localparam int MIN_ON_DELAY_NS  = 156;
  localparam int MIN_ON_DELAY_CYC = (MIN_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_NORMAL_NS    = 220;
  localparam int LEB_NORMAL_CYC   = (LEB_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_BURST_NS     = 180;
  localparam int LEB_BURST_CYC    = (LEB_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_W            = 4;
  // soft start
  localparam int SOFT_STEPS     = 32;
  localparam int SOFT_STEP_W    = 5;
  localparam int SOFT_STEP_US   = 300;
  localparam int SOFT_STEP_CYC  = SOFT_STEP_US * CLK_MHZ;
  localparam int SOFT_TOTAL_MS  = 10;
  localparam int SOFT_TOTAL_CYC = SOFT_TOTAL_MS * CLK_MHZ * 1000;
  localparam int SOFT_LSB_SH    = 7;
  // sense path scaling: gain 3.25 as 13/4
  localparam int SENSE_W        = 10;
  localparam int LVL_W          = 14;
  localparam int GAIN_NUM       = 13;
  localparam int GAIN_SH        = 2;
  localparam int SENSE_LSB_UV   = 1000;
  localparam int SLOPE_MV_PER_US = 50;
  localparam int SLOPE_CODE_PER_CYC = SLOPE_MV_PER_US * CLK_PERIOD_NS / SENSE_LSB_UV;
  localparam int LL_RAMP_CODE_PER_CYC = 1;
  // peak limit thresholds and two-curve compensation
  localparam logic [SENSE_W-1:0] PEAK_LIMIT_CODE  = 10'h2EE;
  localparam logic [SENSE_W-1:0] BURST_LIMIT_CODE = 10'h0D2;
  localparam int RAMP_LONG_US   = 4;
  localparam int RAMP_LONG_CYC  = RAMP_LONG_US * CLK_MHZ;
  localparam int K_SHORT_SH     = 2;
  localparam int K_LONG_SH      = 1;
  localparam int ON_W           = 10;
  // soft start sequencer states
  typedef enum logic [1:0] {SS_IDLE, SS_RAMP, SS_DONE} cmps_ss_state_t;
endpackage

// >>> src/cmps_tmr_if.sv
// timing signals shared by oscillator, soft-start counter and core
// assumes all three sit on the same mclk domain
`timescale 1ns/1ps
interface cmps_tmr_if;
  logic                          cycle_start;
  logic                          on_phase;
  logic                          delay_done;
  logic                          jitter_en;
  logic                          soft_run;
  logic                          soft_restart;
  logic [cmps_pkg::SOFT_STEP_W-1:0] soft_step;
  logic                          soft_active;
  logic                          soft_done;
  modport osc_mp  (input jitter_en, output cycle_start, on_phase, delay_done);
  modport soft_mp (input soft_run, soft_restart, output soft_step, soft_active, soft_done);
  modport core_mp (input cycle_start, on_phase, delay_done, soft_step, soft_active, soft_done,
                   output jitter_en, soft_run, soft_restart);
endinterface

// >>> src/cmps_osc.sv
// fixed-frequency oscillator with triangular period jitter and duty limit
// assumes mclk at 50 MHz and a synchronous active-low reset
`timescale 1ns/1ps
module cmps_osc (
  input wire logic    mclk,
  input wire logic    rstn,
  input wire logic    ce,
  cmps_tmr_if.osc_mp  tif
);
  localparam logic [cmps_pkg::OSC_W-1:0] BASE_PER = cmps_pkg::OSC_W'(cmps_pkg::OSC_PERIOD_CYC);
  localparam logic signed [6:0]          SPAN     = 7'(cmps_pkg::JIT_SPAN_CYC);
  localparam logic [2:0]                 DIV_LAST = 3'(cmps_pkg::JIT_DIV_OSC - 1);

  logic [cmps_pkg::OSC_W-1:0] cnt_ff;
  logic [cmps_pkg::OSC_W-1:0] period_ff;
  logic signed [6:0]          jit_ff;
  logic                       jit_up_ff;
  logic [2:0]                 div_ff;
  logic                       wrap;
  logic [cmps_pkg::OSC_W+1:0] dmax_prod;
  logic [cmps_pkg::OSC_W-1:0] dmax_cnt;

  assign wrap      = (cnt_ff >= period_ff - 10'h001);
  assign dmax_prod = 12'(period_ff) * 12'(cmps_pkg::DMAX_NUM);
  assign dmax_cnt  = dmax_prod[cmps_pkg::OSC_W+1:cmps_pkg::DMAX_SH];

  // period counter, new period taken at each wrap
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_ff    <= 10'h000;
      period_ff <= BASE_PER;
    end else if (ce) begin
      if (wrap) begin
        cnt_ff    <= 10'h000;
        period_ff <= BASE_PER + 10'(jit_ff);
      end else begin
        cnt_ff <= cnt_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      jit_ff    <= 7'sh00;
      jit_up_ff <= 1'b1;
      div_ff    <= 3'h0;
    end else if (ce && wrap) begin
      if (!tif.jitter_en) begin
        jit_ff    <= 7'sh00;
        jit_up_ff <= 1'b1;
        div_ff    <= 3'h0;
      end else if (div_ff != DIV_LAST) begin
        div_ff <= div_ff + 3'h1;
      end else begin
        div_ff <= 3'h0;
        if (jit_up_ff) begin
          jit_ff <= jit_ff + 7'sh01;
          if (jit_ff == SPAN - 7'sh01) jit_up_ff <= 1'b0;
        end else begin
          jit_ff <= jit_ff - 7'sh01;
          if (jit_ff == 7'sh01 - SPAN) jit_up_ff <= 1'b1;
        end
      end
    end
  end

  // trigger, 0.75 duty window and minimum turn-on delay
  // on phase ends at three quarters
  assign tif.cycle_start = (cnt_ff == 10'h000);
  assign tif.on_phase    = (cnt_ff < dmax_cnt);
  assign tif.delay_done  = (cnt_ff >= 10'(cmps_pkg::MIN_ON_DELAY_CYC));
endmodule

// >>> src/cmps_softstart.sv
// 32-step soft-start counter with completion timer
// assumes soft_run is a synchronised level and soft_restart a one-cycle pulse
`timescale 1ns/1ps
module cmps_softstart #(
  parameter int STEP_CYC  = cmps_pkg::SOFT_STEP_CYC,
  parameter int TOTAL_CYC = cmps_pkg::SOFT_TOTAL_CYC
) (
  input wire logic     mclk,
  input wire logic     rstn,
  input wire logic     ce,
  cmps_tmr_if.soft_mp  tif
);
  localparam int PW = $clog2(STEP_CYC + 1);
  localparam int TW = $clog2(TOTAL_CYC + 1);
  localparam logic [cmps_pkg::SOFT_STEP_W-1:0] STEP_MAX = 5'(cmps_pkg::SOFT_STEPS - 1);

  if (STEP_CYC < 1 || STEP_CYC * (cmps_pkg::SOFT_STEPS - 1) >= TOTAL_CYC) begin : g_bad
    $error("soft start step time does not fit the total time");
  end

  cmps_pkg::cmps_ss_state_t      state_ff;
  logic [PW-1:0]                 pre_ff;
  logic [TW-1:0]                 tot_ff;
  logic [cmps_pkg::SOFT_STEP_W-1:0] step_ff;
  logic                          run_q_ff;

  // sequencer: starts on supply good or restart, clears when supply drops
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= cmps_pkg::SS_IDLE;
      pre_ff   <= '0;
      tot_ff   <= '0;
      step_ff  <= '0;
      run_q_ff <= 1'b0;
    end else if (ce) begin
      run_q_ff <= tif.soft_run;
      if (!tif.soft_run) begin
        state_ff <= cmps_pkg::SS_IDLE;
        pre_ff   <= '0;
        tot_ff   <= '0;
        step_ff  <= '0;
      end else if (!run_q_ff || tif.soft_restart) begin
        state_ff <= cmps_pkg::SS_RAMP;
        pre_ff   <= '0;
        tot_ff   <= '0;
        step_ff  <= '0;
      end else begin
        unique case (state_ff)
          cmps_pkg::SS_RAMP: begin
            if (tot_ff == TW'(TOTAL_CYC - 1)) state_ff <= cmps_pkg::SS_DONE;
            tot_ff <= tot_ff + TW'(1);
            if (pre_ff == PW'(STEP_CYC - 1)) begin
              pre_ff <= '0;
              if (step_ff != STEP_MAX) step_ff <= step_ff + 5'h01;
            end else begin
              pre_ff <= pre_ff + PW'(1);
            end
          end
          cmps_pkg::SS_IDLE: begin
            state_ff <= cmps_pkg::SS_IDLE;
          end
          cmps_pkg::SS_DONE: begin
            state_ff <= cmps_pkg::SS_DONE;
          end
        endcase
      end
    end
  end

  assign tif.soft_step   = step_ff;
  assign tif.soft_active = (state_ff == cmps_pkg::SS_RAMP);
  assign tif.soft_done   = (state_ff == cmps_pkg::SS_DONE);
endmodule

// >>> src/cmps_core.sv
// current-mode pwm core with soft start, slope compensation and peak limiting
// assumes sense and feedback codes come from converters clocked by mclk;
// supply threshold flags are asynchronous and are synchronised here
`timescale 1ns/1ps
module cmps_core #(
  parameter int SOFT_STEP_CYC  = cmps_pkg::SOFT_STEP_CYC,
  parameter int SOFT_TOTAL_CYC = cmps_pkg::SOFT_TOTAL_CYC
) (
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire logic                          vcc_above_on_raw,
  input  wire logic                          vcc_below_off_raw,
  input  wire logic                          burst_mode,
  input  wire logic                          restart_req,
  input  wire logic [cmps_pkg::SENSE_W-1:0]  sense_code,
  input  wire logic [cmps_pkg::LVL_W-1:0]    feedback_level_pin,
  output logic                               gate_drive_ff,
  output logic                               ramp_reset_switch_ff,
  output logic                               slope_comp_on_ff,
  output logic                               edge_blank_window_ff,
  output logic                               burst_limit_gate_ff,
  output logic                               soft_sink_on_ff,
  output logic                               soft_done_ff,
  output logic [cmps_pkg::SOFT_STEP_W-1:0]   soft_ramp_level_ff,
  output logic                               limit_trip_ff
);
  localparam int SW = cmps_pkg::SENSE_W;
  localparam int LW = cmps_pkg::LVL_W;

  cmps_tmr_if tif ();

  cmps_osc u_osc (
    .mclk (mclk),
    .rstn (rstn),
    .ce   (ce),
    .tif  (tif.osc_mp)
  );

  cmps_softstart #(
    .STEP_CYC  (SOFT_STEP_CYC),
    .TOTAL_CYC (SOFT_TOTAL_CYC)
  ) u_soft (
    .mclk (mclk),
    .rstn (rstn),
    .ce   (ce),
    .tif  (tif.soft_mp)
  );

  // dynamic limit: base lowered by slope times curve gain, capped at half
  function automatic logic [SW-1:0] comp_thr(
    input logic [SW-1:0] base,
    input logic [SW-1:0] ds,
    input logic          long_ramp
  );
    logic [15:0] corr;
    logic [15:0] cap;
    corr = 16'(ds) << (long_ramp ? cmps_pkg::K_LONG_SH : cmps_pkg::K_SHORT_SH);
    cap  = 16'(base >> 1);
    if (corr > cap) corr = cap;
    return base - corr[SW-1:0];
  endfunction

  logic                vcc_on_s1_ff;
  logic                vcc_on_s2_ff;
  logic                vcc_off_s1_ff;
  logic                vcc_off_s2_ff;
  logic                run_ff;
  logic                latch_ff;
  logic [LW-1:0]       ll_ramp_ff;
  logic [LW-1:0]       slope_ff;
  logic [cmps_pkg::LEB_W-1:0] blank_ff;
  logic [SW-1:0]       sense_prev_ff;
  logic [cmps_pkg::ON_W-1:0]  on_cnt_ff;
  logic                ramp_long_ff;

  logic [15:0]         amp_prod;
  logic [LW-1:0]       amp_lvl;
  logic [LW-1:0]       sum_lvl;
  logic [LW-1:0]       soft_lvl;
  logic [SW-1:0]       dslope;
  logic [SW-1:0]       thr_peak;
  logic [SW-1:0]       thr_burst;
  logic                sense_valid;
  logic                duty_trip;
  logic                soft_trip;
  logic                peak_trip;
  logic                burst_trip;
  logic                latch_clear;
  logic                nxt_latch;
  logic                nxt_gate;

  // supply flags cross into mclk through two flops
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      vcc_on_s1_ff  <= 1'b0;
      vcc_on_s2_ff  <= 1'b0;
      vcc_off_s1_ff <= 1'b1;
      vcc_off_s2_ff <= 1'b1;
    end else if (ce) begin
      vcc_on_s1_ff  <= vcc_above_on_raw;
      vcc_on_s2_ff  <= vcc_on_s1_ff;
      vcc_off_s1_ff <= vcc_below_off_raw;
      vcc_off_s2_ff <= vcc_off_s1_ff;
    end
  end

  // undervoltage lockout with hysteresis: on at turn-on, off below off level
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      run_ff <= 1'b0;
    end else if (ce) begin
      if (vcc_off_s2_ff) run_ff <= 1'b0;
      else if (vcc_on_s2_ff) run_ff <= 1'b1;
    end
  end

  // soft start follows the lockout state; restarts rerun it
  assign tif.soft_run     = run_ff;
  assign tif.soft_restart = restart_req;
  assign tif.jitter_en    = run_ff & tif.soft_done;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ll_ramp_ff <= '0;
    end else if (ce) begin
      if (!tif.on_phase || tif.cycle_start) ll_ramp_ff <= '0;
      else ll_ramp_ff <= ll_ramp_ff + LW'(cmps_pkg::LL_RAMP_CODE_PER_CYC);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      slope_ff <= '0;
    end else if (ce) begin
      if (gate_drive_ff && !burst_mode) slope_ff <= slope_ff + LW'(cmps_pkg::SLOPE_CODE_PER_CYC);
      else slope_ff <= '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      blank_ff <= '0;
    end else if (ce) begin
      if (nxt_gate && !gate_drive_ff) begin
        blank_ff <= burst_mode ? cmps_pkg::LEB_W'(cmps_pkg::LEB_BURST_CYC)
                               : cmps_pkg::LEB_W'(cmps_pkg::LEB_NORMAL_CYC);
      end else if (blank_ff != '0) begin
        blank_ff <= blank_ff - 4'h1;
      end
    end
  end

  // ramp time of last on-time picks the curve
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      on_cnt_ff     <= '0;
      ramp_long_ff  <= 1'b0;
      sense_prev_ff <= '0;
    end else if (ce) begin
      sense_prev_ff <= sense_code;
      if (gate_drive_ff) begin
        if (on_cnt_ff != '1) on_cnt_ff <= on_cnt_ff + 10'h001;
      end else begin
        on_cnt_ff <= '0;
      end
      if (gate_drive_ff && !nxt_gate) begin
        ramp_long_ff <= (on_cnt_ff >= 10'(cmps_pkg::RAMP_LONG_CYC));
      end
    end
  end

  // gain of 13/4 on raw sense, trips masked by blanking
  assign amp_prod = 16'(sense_code) * 16'(cmps_pkg::GAIN_NUM);
  assign amp_lvl  = amp_prod[LW+cmps_pkg::GAIN_SH-1:cmps_pkg::GAIN_SH];
  assign sum_lvl  = amp_lvl + ll_ramp_ff + slope_ff;
  assign soft_lvl = LW'(tif.soft_step) << cmps_pkg::SOFT_LSB_SH;

  // rising sense per cycle, negative slopes count as flat
  assign dslope = (sense_code > sense_prev_ff) ? sense_code - sense_prev_ff : '0;

  assign thr_peak  = comp_thr(cmps_pkg::PEAK_LIMIT_CODE, dslope, ramp_long_ff);
  assign thr_burst = comp_thr(cmps_pkg::BURST_LIMIT_CODE, dslope, ramp_long_ff);

  assign sense_valid = gate_drive_ff && (blank_ff == '0);
  assign duty_trip   = sense_valid && (sum_lvl > feedback_level_pin);
  assign soft_trip   = sense_valid && tif.soft_active && (sum_lvl > soft_lvl);
  assign peak_trip   = sense_valid && (sense_code > thr_peak);
  // burst limit gated by burst flag
  assign burst_trip  = sense_valid && burst_mode && (sense_code > thr_burst);

  // any clear source resets the latch
  assign latch_clear = duty_trip | soft_trip | peak_trip | burst_trip | !tif.on_phase | !run_ff;
  assign nxt_latch   = latch_clear ? 1'b0 : (tif.cycle_start ? 1'b1 : latch_ff);
  // gate qualified by delay, duty and supply
  assign nxt_gate    = nxt_latch && tif.delay_done && tif.on_phase && run_ff;

  // pulse width latch and gate drive
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      latch_ff      <= 1'b0;
      gate_drive_ff <= 1'b0;
    end else if (ce) begin
      latch_ff      <= nxt_latch;
      gate_drive_ff <= nxt_gate;
    end
  end

  // status outputs registered from internal state and the burst flag
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ramp_reset_switch_ff <= 1'b1;
      slope_comp_on_ff     <= 1'b0;
      edge_blank_window_ff <= 1'b0;
      burst_limit_gate_ff  <= 1'b0;
      limit_trip_ff        <= 1'b0;
    end else if (ce) begin
      ramp_reset_switch_ff <= !tif.on_phase;           // ramp held closed
      slope_comp_on_ff     <= nxt_gate && !burst_mode;
      edge_blank_window_ff <= (nxt_gate && !gate_drive_ff) || (blank_ff > 4'h1);
      burst_limit_gate_ff  <= burst_mode;
      limit_trip_ff        <= peak_trip | burst_trip;  // one-cycle pulse
    end
  end

  // sink runs only while soft start active
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      soft_sink_on_ff    <= 1'b0;
      soft_done_ff       <= 1'b0;
      soft_ramp_level_ff <= '0;
    end else if (ce) begin
      soft_sink_on_ff    <= tif.soft_active;
      soft_done_ff       <= tif.soft_done;
      soft_ramp_level_ff <= tif.soft_step;
    end
  end
endmodule

// >>> dv/cmps_core_chk.sv
// port assertions for the pwm core: limits, blanking, duty, soft start
// assumes one mclk domain, rstn synchronous active low, ce held high
`timescale 1ns/1ps
module cmps_core_chk #(
  parameter int SOFT_STEP_CYC  = 10,
  parameter int SOFT_TOTAL_CYC = 400
) (
  input wire logic                         mclk,
  input wire logic                         rstn,
  input wire logic                         ce,
  input wire logic                         vcc_above_on_raw,
  input wire logic                         vcc_below_off_raw,
  input wire logic                         burst_mode,
  input wire logic                         restart_req,
  input wire logic [cmps_pkg::SENSE_W-1:0] sense_code,
  input wire logic [cmps_pkg::LVL_W-1:0]   feedback_level_pin,
  input wire logic                         gate_drive_ff,
  input wire logic                         ramp_reset_switch_ff,
  input wire logic                         slope_comp_on_ff,
  input wire logic                         edge_blank_window_ff,
  input wire logic                         burst_limit_gate_ff,
  input wire logic                         soft_sink_on_ff,
  input wire logic                         soft_done_ff,
  input wire logic [4:0]                   soft_ramp_level_ff,
  input wire logic                         limit_trip_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [19:0] sink_cnt_ff;
  logic [8:0]  on_cnt_ff;
  // length of the current soft-start run
  always_ff @(posedge mclk) begin
    sink_cnt_ff <= soft_sink_on_ff ? sink_cnt_ff + 20'h1 : 20'h0;
  end
  // length of the current gate pulse
  always_ff @(posedge mclk) begin
    on_cnt_ff <= gate_drive_ff ? on_cnt_ff + 9'h1 : 9'h0;
  end
  a_peak_trip: assert property (gate_drive_ff && !edge_blank_window_ff
    && sense_code > 10'h2EE |=> limit_trip_ff && !gate_drive_ff) else $error("peak missed");
  a_burst_trip: assert property (gate_drive_ff && !edge_blank_window_ff
    && burst_mode && sense_code > 10'h0D2 |=> limit_trip_ff) else $error("burst missed");
  a_trip_blanked: assert property (limit_trip_ff |->
    $past(gate_drive_ff) && !$past(edge_blank_window_ff)) else $error("trip in blank");
  // blank length follows the burst flag seen at the turn-on edge
  a_blank_normal: assert property ($rose(gate_drive_ff) && !$past(burst_mode)
    |-> edge_blank_window_ff[*8]) else $error("blank short");
  a_blank_burst: assert property ($rose(gate_drive_ff) && $past(burst_mode)
    |-> ##[8:10] !edge_blank_window_ff) else $error("burst blank long");
  a_min_delay: assert property ($fell(ramp_reset_switch_ff)
    |-> !gate_drive_ff[*7]) else $error("gate too early");
  a_duty_limit: assert property (on_cnt_ff <= 9'h186)
    else $error("duty above limit");
  a_slope_burst: assert property (burst_mode && $past(burst_mode)
    && $past(burst_mode, 2) |-> !slope_comp_on_ff) else $error("slope in burst");
  a_soft_step: assert property ($changed(soft_ramp_level_ff) |->
    soft_ramp_level_ff == 5'h00 || soft_ramp_level_ff == $past(soft_ramp_level_ff) + 5'h01)
    else $error("step jump");
  a_soft_span: assert property (sink_cnt_ff <= 20'(SOFT_TOTAL_CYC + 4)
    && !(soft_done_ff && soft_sink_on_ff)) else $error("soft start overrun");
  c_peak: cover property (limit_trip_ff && !burst_mode);
  c_burst: cover property (limit_trip_ff && burst_mode);
  c_done: cover property ($rose(soft_done_ff));
endmodule
bind cmps_core cmps_core_chk #(.SOFT_STEP_CYC(SOFT_STEP_CYC), .SOFT_TOTAL_CYC(SOFT_TOTAL_CYC))
  cmps_core_chk_i (.mclk, .rstn, .ce, .vcc_above_on_raw, .vcc_below_off_raw, .burst_mode,
  .restart_req, .sense_code, .feedback_level_pin, .gate_drive_ff, .ramp_reset_switch_ff,
  .slope_comp_on_ff, .edge_blank_window_ff, .burst_limit_gate_ff, .soft_sink_on_ff,
  .soft_done_ff, .soft_ramp_level_ff, .limit_trip_ff);

// >>> dv/cmps_sense_model.sv
// switch current seen at the sense input: ramps while the gate is on
// assumes slope and spike_en come from the bench, gate from the core
`timescale 1ns/1ps
module cmps_sense_model (
  input wire logic                     mclk,
  input wire logic                     gate_on,
  input wire logic [7:0]               slope,
  input wire logic                     spike_en,
  output logic [cmps_pkg::SENSE_W-1:0] sense_code
);
  logic [10:0] ramp_ff;
  logic [1:0]  age_ff;
  // current ramps while the switch conducts, saturating at full scale
  always_ff @(posedge mclk) begin
    if (gate_on !== 1'b1) begin
      ramp_ff <= 11'h000;
    end else begin
      ramp_ff <= (ramp_ff + {3'h0, slope} > 11'h3FF) ? 11'h3FF : ramp_ff + {3'h0, slope};
    end
  end
  // turn-on spike lasts three cycles
  always_ff @(posedge mclk) begin
    age_ff <= (gate_on !== 1'b1) ? 2'h0 : ((age_ff == 2'h3) ? 2'h3 : age_ff + 2'h1);
  end
  assign sense_code = (spike_en && gate_on && age_ff != 2'h3) ? 10'h3FF : ramp_ff[9:0];
endmodule

// >>> dv/cmps_core_tb.sv
// self-checking bench for the pwm core driven through the sense model
// assumes shortened soft-start counts; inputs change at falling edges
`timescale 1ns/1ps
module cmps_core_tb;
  localparam int STEP  = 10;
  localparam int TOTAL = 400;
  logic mclk, rstn, ce, vcc_above_on_raw, vcc_below_off_raw, burst_mode, restart_req;
  logic gate_drive_ff, ramp_reset_switch_ff, slope_comp_on_ff, edge_blank_window_ff;
  logic burst_limit_gate_ff, soft_sink_on_ff, soft_done_ff, limit_trip_ff, spike_en, trip, slp;
  logic [cmps_pkg::SENSE_W-1:0] sense_code;
  logic [cmps_pkg::LVL_W-1:0]   feedback_level_pin;
  logic [4:0]                   soft_ramp_level_ff;
  logic [7:0]                   slope;
  int                           err_count, n_compared, w, p, bl, w0;
  cmps_core #(.SOFT_STEP_CYC(STEP), .SOFT_TOTAL_CYC(TOTAL)) cmps_core_i (.mclk, .rstn, .ce,
    .vcc_above_on_raw, .vcc_below_off_raw, .burst_mode, .restart_req, .sense_code,
    .feedback_level_pin, .gate_drive_ff, .ramp_reset_switch_ff, .slope_comp_on_ff,
    .edge_blank_window_ff, .burst_limit_gate_ff, .soft_sink_on_ff, .soft_done_ff,
    .soft_ramp_level_ff, .limit_trip_ff);
  cmps_sense_model cmps_sense_model_i (.mclk, .gate_on(gate_drive_ff), .slope, .spike_en,
    .sense_code);
  // clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic chk_flag(input string nm, input logic ok);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %s expected 1 seen %b", nm, ok);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // k times: skip to a fresh rise, then measure one full period
  task automatic meas(input int k);
    logic prev;
    for (int i = 0; i < k; i++) begin
      p = 0;
      while ((gate_drive_ff === 1'b1 || p == 0) && p < 1200) begin
        @(negedge mclk);
        p++;
      end
      p = 0;
      while (gate_drive_ff !== 1'b1 && p < 1200) begin
        @(negedge mclk);
        p++;
      end
      {w, p, bl, trip, slp, prev} = {32'h0, 32'h0, 32'h0, 3'h1};
      while (p < 1200 && !(gate_drive_ff === 1'b1 && prev === 1'b0)) begin
        w += (gate_drive_ff === 1'b1);
        bl += (edge_blank_window_ff === 1'b1);
        trip |= (limit_trip_ff === 1'b1);
        slp |= (slope_comp_on_ff === 1'b1);
        prev = gate_drive_ff;
        p++;
        @(negedge mclk);
      end
    end
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (soft_done_ff !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic t_uvlo();
    int hi;
    hi = 0;
    repeat (600) begin
      @(negedge mclk);
      hi += (gate_drive_ff !== 1'b0);
    end
    chk_val("gate_high_cycles", 0, hi);
    chk_val("soft_level", 0, soft_ramp_level_ff);
    $display("t_uvlo done");
  endtask
  task automatic t_soft();
    int n;
    {vcc_below_off_raw, vcc_above_on_raw, n} = {2'b01, 32'h0};
    while (soft_sink_on_ff !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk_flag("soft_begins", n >= 3 && n <= 6);
    while (soft_ramp_level_ff !== 5'h01 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (soft_ramp_level_ff === 5'h01 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk_val("step_gap", STEP, n);
    wait_done(n);
    chk_flag("soft_end", soft_ramp_level_ff === 5'h1F && soft_sink_on_ff === 1'b0);
    $display("t_soft done");
  endtask
  task automatic t_shapes();
    int p0;
    meas(1);
    p0 = p;
    meas(4);
    chk_flag("period_range", p >= 480 && p <= 520 && p != p0);
    chk_flag("duty_max", 4 * w <= 3 * p && w > 300 && slp);
    {slope, feedback_level_pin} = {8'h04, 14'h0400};
    meas(2);
    chk_flag("pwm_width", w >= 60 && w <= 72 && !trip);
    w0 = w;
    feedback_level_pin = 14'h0200;
    meas(2);
    chk_flag("pwm_shorter", w < w0);
    {slope, feedback_level_pin} = {8'h08, 14'h3FFF};
    meas(2);
    // short curve: limit lowered by 4 x 8 codes, trip at sense 720
    chk_flag("peak_trip", trip && w == 91);
    slope = 8'hFF;
    meas(2);
    chk_flag("peak_fast", trip && w == cmps_pkg::LEB_NORMAL_CYC + 1);
    {slope, spike_en} = {8'h00, 1'b1};
    meas(2);
    chk_flag("spike_ignored", !trip && w > 300);
    chk_val("blank_len", cmps_pkg::LEB_NORMAL_CYC, bl);
    {slope, spike_en, burst_mode} = {8'h20, 2'b01};
    meas(2);
    chk_flag("burst_trip", trip && w == cmps_pkg::LEB_BURST_CYC + 1 && !slp);
    chk_val("blank_burst", cmps_pkg::LEB_BURST_CYC, bl);
    chk_val("burst_gate", 1, burst_limit_gate_ff);
    burst_mode = 1'b0;
    $display("t_shapes done");
  endtask
  task automatic t_restart();
    int n;
    restart_req = 1'b1;
    @(negedge mclk);
    restart_req = 1'b0;
    repeat (3) @(negedge mclk);
    chk_flag("restart_soft", soft_done_ff === 1'b0 && soft_sink_on_ff === 1'b1);
    wait_done(n);
    chk_flag("rerun_end", soft_ramp_level_ff === 5'h1F && n < 600);
    {vcc_below_off_raw, vcc_above_on_raw} = 2'b10;
    repeat (8) @(negedge mclk);
    chk_flag("soft_cleared", soft_done_ff === 1'b0 && soft_sink_on_ff === 1'b0);
    $display("t_restart done");
  endtask
  // reset, then the scenarios in order
  initial begin
    {rstn, ce, vcc_above_on_raw, vcc_below_off_raw, burst_mode, restart_req} = 6'b010100;
    {slope, spike_en, feedback_level_pin, err_count, n_compared} = '0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    t_uvlo();
    t_soft();
    feedback_level_pin = 14'h3FFF;
    t_shapes();
    t_restart();
    t_uvlo();
    summarize();
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    summarize();
  end
endmodule
